// ===== pkg/hrsq_pkg.sv
// shared constants and types for the hard-reset sequencer
package hrsq_pkg;
   localparam int unsigned CLK_PERIOD_PS        = 4000;
   // least times in ns, round up to cycles
   localparam int unsigned INIT_ASSERT_TO_SELECT_NS = 400;
   localparam int unsigned INIT_ASSERT_TO_SELECT_CYC =
      (INIT_ASSERT_TO_SELECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned INIT_PULSE_MIN_NS    = 200;
   localparam int unsigned INIT_PULSE_MIN_CYC =
      (INIT_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned INIT_RELEASE_TO_SELECT_NS = 200;
   localparam int unsigned INIT_RELEASE_TO_SELECT_CYC =
      (INIT_RELEASE_TO_SELECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // two synchroniser stages and the edge detector that come before the hold-off count
   localparam int unsigned HOLD_PIPE_CYC        = 3;
   // self-init time in us, the longest figure, rounded down
   localparam int unsigned POWERUP_SELFINIT_TIME_US = 150;
   localparam int unsigned POWERUP_SELFINIT_CYC =
      (POWERUP_SELFINIT_TIME_US * 1000000) / CLK_PERIOD_PS;
   localparam int unsigned ROW_W                = 13;
   localparam logic [12:0] ROW_DEFAULT          = 13'h0000;
   localparam int unsigned CFG_W                = 16;
   localparam logic [15:0] CFG_DEFAULT          = 16'h8F1F;
   localparam int unsigned HOLD_W               = 8;

   typedef enum logic [2:0] {
      HRSQ_ST_INIT    = 3'h0,
      HRSQ_ST_RESET   = 3'h1,
      HRSQ_ST_HOLDOFF = 3'h2,
      HRSQ_ST_SELFINI = 3'h3,
      HRSQ_ST_READY   = 3'h4
   } hrsq_state_t;

   typedef enum logic [1:0] {
      HRSQ_PWR_ACTIVE = 2'h0,
      HRSQ_PWR_HYBRID = 2'h1,
      HRSQ_PWR_DEEP   = 2'h2
   } hrsq_pwr_t;

   // power-state requests from the transaction logic
   typedef struct packed {
      logic hybrid_enter;
      logic deepest_enter;
      logic wake;
   } hrsq_pwr_req_t;

   typedef struct packed {
      logic            refresh_run;
      logic            array_valid;
      logic            bus_enable;
      logic [ROW_W-1:0] row;
   } hrsq_stat_t;
endpackage

// ===== logic/hrsq_core.sv
// hard-reset sequencer: standby return, config defaults, refresh control
`timescale 1ns/1ps
`default_nettype none
// How it works
// - with reset pin low the device sits in standby, dropping any operation or sleep state.
// - a reset pin low restores the configuration register to its default value.
// - self-refresh stops while the reset pin is low and the array is marked invalid.
// - a reset pin low takes the device out of hybrid sleep.
// - a reset pin low takes the device out of the deepest sleep state.
// - on reset release refresh restarts with the row counter back at its default.
// - a reset low at power-up delays the self-init interval until reset goes high.
module hrsq_core
   import hrsq_pkg::*;
#(
   parameter int unsigned SELFINIT_CYC = POWERUP_SELFINIT_CYC
) (
   input  wire logic              clock_in,
   input  wire logic              arst_n_in,
   input  wire logic              reset_pin_n_in,
   input  wire logic              select_n_in,
   input  wire logic              cfg_we_in,
   input  wire logic [CFG_W-1:0]  cfg_wdata_in,
   input  wire hrsq_pwr_req_t     pwr_req_in,
   input  wire logic              refresh_tick_in,
   output logic                   txn_start_out,
   output logic [CFG_W-1:0]       cfg_out,
   output hrsq_pwr_t              pwr_state_out,
   output hrsq_stat_t             stat_out
);
   // pin synchronisers, first stage read only by the second
   logic rst_s1_ff;
   logic rst_s2_ff;
   logic sel_s1_ff;
   logic sel_s2_ff;
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
         sel_s1_ff <= 1'b1;
         sel_s2_ff <= 1'b1;
      end else begin
         rst_s1_ff <= reset_pin_n_in;
         rst_s2_ff <= rst_s1_ff;
         sel_s1_ff <= select_n_in;
         sel_s2_ff <= sel_s1_ff;
      end
   end

   logic pin_low;
   assign pin_low = !rst_s2_ff;

   localparam int unsigned SI_W = $clog2(SELFINIT_CYC + 1);
   hrsq_state_t       state_ff;
   hrsq_state_t       nxt_state;
   logic [HOLD_W-1:0] hold_cnt_ff;
   logic [SI_W-1:0]   si_cnt_ff;
   logic              sel_prev_ff;
   logic              pin_low_prev_ff;
   logic [HOLD_W-1:0] since_fall_ff;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         HRSQ_ST_INIT:    nxt_state = pin_low ? HRSQ_ST_INIT : HRSQ_ST_SELFINI;
         HRSQ_ST_RESET:   nxt_state = pin_low ? HRSQ_ST_RESET : HRSQ_ST_HOLDOFF;
         HRSQ_ST_HOLDOFF: begin
            if (pin_low)
               nxt_state = HRSQ_ST_RESET;
            else if (hold_cnt_ff == '0)
               nxt_state = HRSQ_ST_READY;
         end
         HRSQ_ST_SELFINI: begin
            if (pin_low)
               nxt_state = HRSQ_ST_INIT;
            else if (si_cnt_ff == '0 && hold_cnt_ff == '0)
               nxt_state = HRSQ_ST_READY;
         end
         HRSQ_ST_READY:   nxt_state = pin_low ? HRSQ_ST_RESET : HRSQ_ST_READY;
         default:         nxt_state = HRSQ_ST_INIT;
      endcase
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in)
         state_ff <= HRSQ_ST_INIT;
      else
         state_ff <= nxt_state;
   end

   // seen low during arst, so the release of arst gives no false fall
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in)
         pin_low_prev_ff <= 1'b1;
      else
         pin_low_prev_ff <= pin_low;
   end

   // hold-off counts from every reset fall; pulse width covered by staying in reset
   // shortened by the pipeline so a select at exactly the least time is taken
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in)
         hold_cnt_ff <= '0;
      else if (pin_low && !pin_low_prev_ff)
         hold_cnt_ff <= HOLD_W'(INIT_ASSERT_TO_SELECT_CYC - HOLD_PIPE_CYC);
      else if (hold_cnt_ff != '0)
         hold_cnt_ff <= hold_cnt_ff - HOLD_W'(1);
   end

   // checker helper: cycles since the last synced reset fall, saturating
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in)
         since_fall_ff <= HOLD_W'(INIT_ASSERT_TO_SELECT_CYC);
      else if (pin_low && !pin_low_prev_ff)
         since_fall_ff <= '0;
      else if (since_fall_ff != HOLD_W'(INIT_ASSERT_TO_SELECT_CYC))
         since_fall_ff <= since_fall_ff + HOLD_W'(1);
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in)
         si_cnt_ff <= SI_W'(SELFINIT_CYC);
      else if (state_ff == HRSQ_ST_INIT)
         si_cnt_ff <= SI_W'(SELFINIT_CYC);
      else if (state_ff == HRSQ_ST_SELFINI && si_cnt_ff != '0)
         si_cnt_ff <= si_cnt_ff - SI_W'(1);
   end

   logic bus_ok;
   assign bus_ok = (state_ff == HRSQ_ST_READY) && !pin_low;

   // a select that was already low when the bus opened starts nothing
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sel_prev_ff   <= 1'b1;
         txn_start_out <= 1'b0;
      end else begin
         sel_prev_ff   <= bus_ok ? sel_s2_ff : 1'b0;
         txn_start_out <= bus_ok && sel_prev_ff && !sel_s2_ff;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in)
         cfg_out <= CFG_DEFAULT;
      else if (pin_low)
         cfg_out <= CFG_DEFAULT;
      else if (bus_ok && cfg_we_in)
         cfg_out <= cfg_wdata_in;
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in)
         pwr_state_out <= HRSQ_PWR_ACTIVE;
      else if (pin_low)
         pwr_state_out <= HRSQ_PWR_ACTIVE;
      else if (bus_ok) begin
         if (pwr_req_in.deepest_enter)
            pwr_state_out <= HRSQ_PWR_DEEP;
         else if (pwr_req_in.hybrid_enter)
            pwr_state_out <= HRSQ_PWR_HYBRID;
         else if (pwr_req_in.wake)
            pwr_state_out <= HRSQ_PWR_ACTIVE;
      end
   end

   // refresh stops in the deepest state too, since that state keeps no data
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stat_out <= '{refresh_run: 1'b0, array_valid: 1'b0, bus_enable: 1'b0,
                       row: ROW_DEFAULT};
      end else begin
         stat_out.refresh_run <= !pin_low && pwr_state_out != HRSQ_PWR_DEEP;
         stat_out.bus_enable  <= (nxt_state == HRSQ_ST_READY) && !pin_low;
         if (pin_low)
            stat_out.array_valid <= 1'b0;
         else if (state_ff == HRSQ_ST_SELFINI && si_cnt_ff == '0)
            stat_out.array_valid <= 1'b1;
         if (pin_low)
            stat_out.row <= ROW_DEFAULT;
         else if (stat_out.refresh_run && refresh_tick_in)
            stat_out.row <= stat_out.row + ROW_W'(1);
      end
   end

   property p_cfg_default;
      @(posedge clock_in) disable iff (!arst_n_in)
      pin_low |=> (cfg_out == CFG_DEFAULT);
   endproperty
   a_cfg_default: assert property (p_cfg_default) else $error("config not default in reset");

   property p_no_refresh;
      @(posedge clock_in) disable iff (!arst_n_in)
      pin_low |=> (!stat_out.refresh_run && !stat_out.array_valid);
   endproperty
   a_no_refresh: assert property (p_no_refresh) else $error("refresh ran in reset");

   property p_exit_sleep;
      @(posedge clock_in) disable iff (!arst_n_in)
      pin_low |=> (pwr_state_out == HRSQ_PWR_ACTIVE);
   endproperty
   a_exit_sleep: assert property (p_exit_sleep) else $error("sleep kept in reset");

   property p_row_restart;
      @(posedge clock_in) disable iff (!arst_n_in)
      (pin_low ##1 !pin_low) |=> (stat_out.row == ROW_DEFAULT && stat_out.refresh_run);
   endproperty
   a_row_restart: assert property (p_row_restart) else $error("row not restarted");

   property p_holdoff;
      @(posedge clock_in) disable iff (!arst_n_in)
      $fell(rst_s2_ff) && state_ff == HRSQ_ST_READY |=> !txn_start_out [*8];
   endproperty
   a_holdoff: assert property (p_holdoff) else $error("transaction in hold-off");

   property p_holdoff_span;
      @(posedge clock_in) disable iff (!arst_n_in)
      txn_start_out |-> (since_fall_ff == HOLD_W'(INIT_ASSERT_TO_SELECT_CYC));
   endproperty
   a_holdoff_span: assert property (p_holdoff_span) else $error("start inside hold-off");

   property p_standby;
      @(posedge clock_in) disable iff (!arst_n_in)
      pin_low |=> (!stat_out.bus_enable && !txn_start_out);
   endproperty
   a_standby: assert property (p_standby) else $error("not standby in reset");

   property p_selfinit_defer;
      @(posedge clock_in) disable iff (!arst_n_in)
      (state_ff == HRSQ_ST_INIT) |-> (si_cnt_ff == SI_W'(SELFINIT_CYC) || $past(state_ff) != HRSQ_ST_INIT);
   endproperty
   a_selfinit_defer: assert property (p_selfinit_defer) else $error("self-init not deferred");

   property p_start_gated;
      @(posedge clock_in) disable iff (!arst_n_in)
      txn_start_out |-> $past(state_ff) == HRSQ_ST_READY;
   endproperty
   a_start_gated: assert property (p_start_gated) else $error("start outside ready");
endmodule
`default_nettype wire

// ===== tb/hrsq_host_model.sv
// host model: drives the hard reset pin and chip select
`timescale 1ns/1ps
`default_nettype none
module hrsq_host_model
   import hrsq_pkg::*;
(
   input  wire logic clock_in,
   output var logic  reset_pin_n_out,
   output var logic  select_n_out
);
   int now = 0;
   int fall_at = 0;
   int rise_at = 0;
   initial reset_pin_n_out = 1'b0;
   initial select_n_out = 1'b1;
   always @(posedge clock_in) now <= now + 1;
   task automatic press_reset();
      reset_pin_n_out = 1'b0;
      fall_at = now;
   endtask
   // least reset pulse, in cycles
   task automatic free_reset();
      while (now - fall_at < int'(INIT_PULSE_MIN_CYC)) begin
         @(posedge clock_in);
         #1;
      end
      reset_pin_n_out = 1'b1;
      rise_at = now;
   endtask
   // early skips the spacing, so a refusal can be provoked
   task automatic pulse_select(input int len, input bit early);
      while (!early && (!reset_pin_n_out ||
                        now - rise_at < int'(INIT_RELEASE_TO_SELECT_CYC) ||
                        now - fall_at < int'(INIT_ASSERT_TO_SELECT_CYC))) begin
         @(posedge clock_in);
         #1;
      end
      select_n_out = 1'b0;
      repeat (len) @(posedge clock_in);
      #1 select_n_out = 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== tb/hrsq_core_bench.sv
// self-checking bench for the hard-reset sequencer
`timescale 1ns/1ps
`default_nettype none
module hrsq_core_bench
   import hrsq_pkg::*;
;
   logic          clock_in = 1'b0;
   logic          arst_n_in = 1'b0;
   logic          rst_pin_n;
   logic          sel_n;
   logic          cfg_we = 1'b0;
   logic [15:0]   cfg_wd = 16'h0000;
   hrsq_pwr_req_t pwr_req = 3'h0;
   logic          tick = 1'b0;
   logic          txn;
   logic [15:0]   cfg;
   hrsq_pwr_t     pwr;
   hrsq_pwr_t     pe = HRSQ_PWR_ACTIVE;
   hrsq_stat_t    stat;
   logic [15:0]   flags;
   int            n_mismatch = 0;
   int            tests_run = 0;
   int            n_start = 0;
   int            cyc = 0;
   int            k;
   integer        seed = 65;
   logic [15:0]   w;
   assign flags = {13'h0000, stat.refresh_run, stat.array_valid, stat.bus_enable};
   always #2 clock_in = ~clock_in;
   hrsq_core #(.SELFINIT_CYC(20)) dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .reset_pin_n_in(rst_pin_n), .select_n_in(sel_n), .cfg_we_in(cfg_we),
      .cfg_wdata_in(cfg_wd), .pwr_req_in(pwr_req), .refresh_tick_in(tick),
      .txn_start_out(txn), .cfg_out(cfg), .pwr_state_out(pwr), .stat_out(stat));
   hrsq_host_model host_u (.clock_in(clock_in), .reset_pin_n_out(rst_pin_n),
      .select_n_out(sel_n));
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (txn === 1'b1) n_start <= n_start + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         final_report();
      end
   end
   function automatic hrsq_pwr_t pwr_of(hrsq_pwr_req_t r, hrsq_pwr_t p);
      return r.deepest_enter ? HRSQ_PWR_DEEP : r.hybrid_enter ? HRSQ_PWR_HYBRID :
             r.wake ? HRSQ_PWR_ACTIVE : p;
   endfunction
   task automatic final_report();
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic wr_cfg(input logic [15:0] d);
      cfg_we = 1'b1;
      cfg_wd = d;
      step(1);
      cfg_we = 1'b0;
      step(1);
      chk(cfg, d);
   endtask
   task automatic ticks(input int n);
      tick = 1'b1;
      step(n);
      tick = 1'b0;
      chk({3'h0, stat.row}, 16'(n));
   endtask
   task automatic wait_ready();
      for (k = 0; k < 200 && stat.bus_enable !== 1'b1; k++) step(1);
   endtask
   initial begin
      step(4);
      arst_n_in = 1'b1;
      step(30);
      chk(flags, 16'h0000);
      host_u.free_reset();
      host_u.pulse_select(3, 1'b1);
      step(4);
      chk(16'(n_start), 16'h0000);
      wait_ready();
      chk(flags, 16'h0007);
      host_u.pulse_select(3, 1'b0);
      step(6);
      chk(16'(n_start), 16'h0001);
      for (int i = 0; i < 3; i++) wr_cfg(16'($random(seed)));
      ticks(($random(seed) & 15) + 1);
      for (int i = 0; i < 8; i++) begin
         pwr_req = 3'($random(seed));
         pe = pwr_of(pwr_req, pe);
         step(1);
         pwr_req = 3'h0;
         step(1);
         chk({14'h0000, pwr}, {14'h0000, pe});
      end
      for (int m = 0; m < 2; m++) begin
         wr_cfg(16'h70E0);
         pwr_req = (m == 0) ? 3'h4 : 3'h2;
         step(1);
         pwr_req = 3'h0;
         chk({14'h0000, pwr}, (m == 0) ? 16'h0001 : 16'h0002);
         host_u.press_reset();
         step(4);
         chk(cfg, CFG_DEFAULT);
         chk({14'h0000, pwr}, 16'h0000);
         chk(flags, 16'h0000);
         // ticks and a select while held in reset must both be ignored
         tick = 1'b1;
         host_u.pulse_select(2, 1'b1);
         tick = 1'b0;
         chk({3'h0, stat.row}, 16'h0000);
         host_u.free_reset();
         step(10);
         chk(flags, 16'h0004);
         host_u.pulse_select(3, 1'b1);
         step(4);
         chk(16'(n_start), 16'(2 * m + 1));
         // a select at exactly the least spacing must be taken
         host_u.pulse_select(3, 1'b0);
         step(6);
         chk(16'(n_start), 16'(2 * m + 2));
         wait_ready();
         chk(flags, 16'h0005);
         chk({3'h0, stat.row}, 16'h0000);
         ticks(3);
         wr_cfg(16'($random(seed)));
         host_u.pulse_select(3, 1'b0);
         step(6);
         chk(16'(n_start), 16'(2 * m + 3));
      end
      final_report();
   end
endmodule
`default_nettype wire
